/* common/comparator_group_pkg.sv */
// Constants shared by the comparator group control logic.
// Assumes an 8-bit register port and a 100 MHz system clock.
package comparator_group_pkg;

  // Register offsets
  localparam logic [7:0] GROUP_CONTROL_REG_OFS  = 8'hDA;
  localparam logic [7:0] SAMPLING_ROUTE_REG_OFS = 8'hDB;
  localparam logic [7:0] AUX_CONTROL_REG_OFS    = 8'hDC;
  localparam logic [7:0] SAMPLE_ON_DELAY_OFS    = 8'hDD;
  localparam logic [7:0] SAMPLE_OFF_LEAD_OFS    = 8'hDE;
  localparam logic [7:0] RESULT_STATUS_OFS      = 8'hDF;

  // Field positions
  localparam int MODE_LSB    = 5;
  localparam int PICK_LSB    = 3;
  localparam int SAMPLE_SEL_LSB = 0;
  localparam int ROUTE_LSB   = 2;
  localparam int AUX_EN_BIT  = 0;
  localparam int SWITCH_BIT  = 1;
  localparam int AUX_OUT_BIT = 7;

  // Reset values
  localparam logic [7:0] GROUP_CONTROL_RST  = 8'h00;
  localparam logic [7:0] SAMPLING_ROUTE_RST = 8'h00;
  localparam logic [7:0] AUX_CONTROL_RST    = 8'h00;
  localparam logic [7:0] ON_DELAY_RST       = 8'h00;
  localparam logic [7:0] OFF_LEAD_RST       = 8'h00;

  // Input filter length in clock cycles
  localparam int FILT_CYCLES = 4;

  typedef enum logic [1:0] {
    MODE_EXT_NEUTRAL = 2'b00,
    MODE_RES_NEUTRAL = 2'b01,
    MODE_DIFF_HALL   = 2'b10,
    MODE_TWO_COMP    = 2'b11
  } group_mode_t;

  typedef enum logic [1:0] {
    SAM_OFF  = 2'b00,
    SAM_HIGH = 2'b01,
    SAM_LOW  = 2'b10,
    SAM_RSVD = 2'b11
  } sampling_select_t;

  typedef enum logic [2:0] {
    ROUTE_NONE = 3'b000,
    ROUTE_A    = 3'b001,
    ROUTE_B    = 3'b010,
    ROUTE_C    = 3'b011,
    ROUTE_FUNC = 3'b100
  } route_t;

endpackage : comparator_group_pkg

/* rtl/comparator_group_sampling_ctrl.sv */
// Digital control of the three-comparator group, sampling window and routing.
// Assumes raw comparator levels and PWM arrive asynchronously on pins.
//
// What this block does
// - Mode 00: three comparators, shared external negative pin, three results.
// - Three-comparator modes: pick 00 all, 01 first, 10 second, 11 third.
// - Mode 01: all negatives tied to internal resistor neutral point.
// - Mode 01: switch bit 1 gives second and third comparators alternate pins.
// - Mode 10: three differential comparators with own negative and positive pins.
// - Mode 11: only first two comparators run, sharing one negative pin.
// - Two-comparator mode: pick 00 both, 01 first, 10 second.
// - Results pass filtering then sampling before reaching the capture timer.
// - Window opens only after the on-delay from the relevant PWM edge.
// - Window closes on-delay minus off-lead after the PWM falling edge.
// - Low-level sampling uses the same timing on the PWM off interval.
// - Sampling select 00 disables windowing; results pass straight through.
// - Route select drives one comparator to test pin or selects functional route.
// - Aux comparator runs only while enabled; its output is readable.
// - Comparator pick sits at bits 4:3 of group control, with mode field.
`timescale 1ns/1ps
`default_nettype none
module comparator_group_sampling_ctrl
  import comparator_group_pkg::*;
#(
  parameter int CNT_W = 9
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Analog comparator raw outputs
  input  wire logic [2:0] comp_raw,
  input  wire logic       aux_raw,
  // PWM reference
  input  wire logic       pwm_in,
  // Analog topology controls
  output logic      [2:0] comp_enable,
  output logic            neg_shared_ext,
  output logic            neg_resistor,
  output logic            neg_diff,
  output logic            pos_alt_b,
  output logic            pos_alt_c,
  output logic            aux_comparator_enable,
  // Results to capture timer
  output logic      [2:0] timer_result,
  // Route pins
  output logic            test_pin,
  output logic            func_pin
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] group_ctl_q;
  logic [7:0] route_ctl_q;
  logic [7:0] aux_ctl_q;
  logic [7:0] on_delay_q;
  logic [7:0] off_lead_q;

  group_mode_t      mode;
  sampling_select_t sample_sel;
  route_t           route;
  logic [1:0]       pick;

  assign pick   = group_ctl_q[PICK_LSB +: 2];
  assign mode   = group_mode_t'(group_ctl_q[MODE_LSB +: 2]);
  assign sample_sel = sampling_select_t'(route_ctl_q[SAMPLE_SEL_LSB +: 2]);
  assign route  = route_t'(route_ctl_q[ROUTE_LSB +: 3]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      group_ctl_q <= GROUP_CONTROL_RST;
      route_ctl_q <= SAMPLING_ROUTE_RST;
      aux_ctl_q   <= AUX_CONTROL_RST;
      on_delay_q  <= ON_DELAY_RST;
      off_lead_q  <= OFF_LEAD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        GROUP_CONTROL_REG_OFS:  group_ctl_q <= reg_wdata & 8'h78;
        SAMPLING_ROUTE_REG_OFS: route_ctl_q <= reg_wdata & 8'h1F;
        AUX_CONTROL_REG_OFS:    aux_ctl_q   <= reg_wdata & 8'h03;
        SAMPLE_ON_DELAY_OFS:    on_delay_q  <= reg_wdata;
        SAMPLE_OFF_LEAD_OFS:    off_lead_q  <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation and filtering

  logic [3:0] filt;
  logic       pwm_s;

  sync_filter #(
    .WIDTH  (4),
    .STABLE (FILT_CYCLES)
  ) u_comp_filt (
    .clk  (clk),
    .nrst (nrst),
    .din  ({aux_raw, comp_raw}),
    .dout (filt)
  );

  // PWM is only synchronised, a filter would skew window timing
  sync_filter #(
    .WIDTH  (1),
    .STABLE (1)
  ) u_pwm_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (pwm_in),
    .dout (pwm_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Topology decode

  function automatic logic [2:0] pick_decode(input group_mode_t m,
                                             input logic [1:0] p);
    logic [2:0] en;
    en = 3'b000;
    if (m == MODE_TWO_COMP) begin
      case (p)
        2'b00:   en = 3'b011;
        2'b01:   en = 3'b001;
        2'b10:   en = 3'b010;
        default: en = 3'b000;
      endcase
    end else begin
      case (p)
        2'b00:   en = 3'b111;
        2'b01:   en = 3'b001;
        2'b10:   en = 3'b010;
        default: en = 3'b100;
      endcase
    end
    return en;
  endfunction : pick_decode

  logic [2:0] en_d;
  assign en_d = pick_decode(mode, pick);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_enable    <= 3'h0;
      neg_shared_ext <= 1'b0;
      neg_resistor   <= 1'b0;
      neg_diff       <= 1'b0;
      pos_alt_b      <= 1'b0;
      pos_alt_c      <= 1'b0;
    end else begin
      comp_enable    <= en_d;
      neg_shared_ext <= (mode == MODE_EXT_NEUTRAL) || (mode == MODE_TWO_COMP);
      neg_resistor   <= (mode == MODE_RES_NEUTRAL);
      neg_diff       <= (mode == MODE_DIFF_HALL);
      pos_alt_b      <= ((mode == MODE_RES_NEUTRAL) && aux_ctl_q[SWITCH_BIT])
                        || (mode == MODE_TWO_COMP);
      pos_alt_c      <= (mode == MODE_RES_NEUTRAL) && aux_ctl_q[SWITCH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling window timing

  logic             pwm_d1_q;
  logic [CNT_W-1:0] cnt_q;
  logic             window_q;
  logic             edge_seen;
  logic             in_phase;
  logic [CNT_W-1:0] on_cnt;
  logic [CNT_W-1:0] close_cnt;
  logic             window_d;

  assign edge_seen = pwm_s ^ pwm_d1_q;
  assign on_cnt    = CNT_W'(on_delay_q);
  // Off-lead beyond on-delay closes right at the edge
  assign close_cnt = (off_lead_q >= on_delay_q) ? '0 :
                     CNT_W'(on_delay_q - off_lead_q);
  assign in_phase  = (sample_sel == SAM_LOW) ? ~pwm_s : pwm_s;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_d1_q <= 1'b0;
      cnt_q    <= '0;
    end else begin
      pwm_d1_q <= pwm_s;
      if (edge_seen) begin
        cnt_q <= '0;
      end else if (cnt_q != {CNT_W{1'b1}}) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    window_d = 1'b0;
    if (edge_seen) begin
      window_d = in_phase ? (on_cnt == '0) : (window_q && (close_cnt != '0));
    end else if (in_phase) begin
      window_d = ({1'b0, cnt_q} + 1'b1) >= {1'b0, on_cnt};
    end else begin
      window_d = window_q && (({1'b0, cnt_q} + 1'b1) < {1'b0, close_cnt});
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      window_q <= 1'b0;
    end else begin
      window_q <= window_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling stage

  logic [2:0] gated;
  assign gated = filt[2:0] & comp_enable;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_result <= 3'h0;
    end else if (sample_sel == SAM_OFF) begin
      timer_result <= gated;
    end else begin
      timer_result <= window_q ? gated : timer_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output routing and aux comparator

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      test_pin <= 1'b0;
      func_pin <= 1'b0;
    end else begin
      case (route)
        ROUTE_A: test_pin <= gated[0];
        ROUTE_B: test_pin <= gated[1];
        ROUTE_C: test_pin <= gated[2];
        default: test_pin <= 1'b0;
      endcase
      func_pin <= (route == ROUTE_FUNC) ? timer_result[0] : 1'b0;
    end
  end

  logic aux_level_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aux_comparator_enable <= 1'b0;
      aux_level_q           <= 1'b0;
    end else begin
      aux_comparator_enable <= aux_ctl_q[AUX_EN_BIT];
      aux_level_q           <= aux_ctl_q[AUX_EN_BIT] & filt[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        GROUP_CONTROL_REG_OFS:  reg_rdata <= group_ctl_q;
        SAMPLING_ROUTE_REG_OFS: reg_rdata <= route_ctl_q;
        AUX_CONTROL_REG_OFS:    reg_rdata <= {aux_level_q, aux_ctl_q[6:0]};
        SAMPLE_ON_DELAY_OFS:    reg_rdata <= on_delay_q;
        SAMPLE_OFF_LEAD_OFS:    reg_rdata <= off_lead_q;
        RESULT_STATUS_OFS:      reg_rdata <= {4'h0, window_q, timer_result};
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : comparator_group_sampling_ctrl
`default_nettype wire

/* rtl/sync_filter.sv */
// Two-flop synchroniser followed by a stability filter.
// Assumes asynchronous inputs; output changes only after STABLE equal samples.
`timescale 1ns/1ps
`default_nettype none
module sync_filter #(
  parameter int WIDTH  = 1,
  parameter int STABLE = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  localparam int CW = $clog2(STABLE + 1);
  localparam logic [CW-1:0] CMAX = CW'(STABLE - 1);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [CW-1:0] cnt_q;
      logic          out_q;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cnt_q <= '0;
          out_q <= 1'b0;
        end else if (sync_q[g] == out_q) begin
          cnt_q <= '0;
        end else if (cnt_q >= CMAX) begin
          cnt_q <= '0;
          out_q <= sync_q[g];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
      assign dout[g] = out_q;
    end
  endgenerate

endmodule : sync_filter
`default_nettype wire

/* sim/comparator_group_sampling_ctrl_sva.sv */
// Checker on the ports of the comparator group control.
// Assumes the write-to-output latency of two cycles.
`timescale 1ns/1ps
`default_nettype none
module comparator_group_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Topology and route outputs
  input wire logic [2:0] comp_enable,
  input wire logic       neg_shared_ext,
  input wire logic       neg_resistor,
  input wire logic       neg_diff,
  input wire logic       pos_alt_b,
  input wire logic       pos_alt_c,
  input wire logic       aux_comparator_enable,
  input wire logic       test_pin,
  input wire logic       func_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic wr_da = reg_wr && reg_addr == 8'hDA;
  wire logic wr_dc = reg_wr && reg_addr == 8'hDC;
  function automatic logic [2:0] en_of(input logic [7:0] w);
    if (w[4:3] == 2'b00) return (w[6:5] == 2'b11) ? 3'b011 : 3'b111;
    if (w[4:3] == 2'b11) return (w[6:5] == 2'b11) ? 3'b000 : 3'b100;
    return {1'b0, w[4:3] == 2'b10, w[4:3] == 2'b01};
  endfunction : en_of
  ////////////////////////////////////////
  a_pick_enable:
    assert property (wr_da |-> ##2 comp_enable == en_of($past(reg_wdata, 2))) else $error("bad comp enable");
  a_neg_route:
    assert property (wr_da ##1 !$past(reg_wdata[5]) && $past(reg_wdata[6]) |=> neg_diff && !neg_shared_ext)
    else $error("bad negative route");
  a_alt_pins:
    assert property (pos_alt_c |-> neg_resistor && pos_alt_b) else $error("alt pin outside resistor mode");
  a_two_comp:
    assert property (neg_shared_ext && pos_alt_b |-> comp_enable[2] == 1'b0) else $error("third on in two mode");
  a_aux_enable:
    assert property (wr_dc |-> ##2 aux_comparator_enable == $past(reg_wdata[0], 2)) else $error("bad aux enable");
  a_read_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
  a_unmapped_read:
    assert property (reg_rd && (reg_addr < 8'hDA || reg_addr > 8'hDF) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_route_idle:
    assert property (reg_wr && reg_addr == 8'hDB && reg_wdata[4:2] == 3'h0 |-> ##2 !test_pin && !func_pin)
    else $error("route pins active with no route");
endmodule : comparator_group_sva
bind comparator_group_sampling_ctrl comparator_group_sva u_sva (.*);
`default_nettype wire

/* sim/comparator_group_sampling_ctrl_tb_top.sv */
// Self-checking bench for the comparator group control.
// Assumes fixed filter, synchroniser and register latencies of the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module comparator_group_sampling_ctrl_tb_top;
  import comparator_group_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, aux_raw = 1'b0, pwm_in;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, hi_len = 8'h28, lo_len = 8'h28;
  logic [2:0] comp_raw = 3'b000, comp_enable, timer_result;
  logic neg_shared_ext, neg_resistor, neg_diff, pos_alt_b, pos_alt_c, aux_comparator_enable, test_pin, func_pin;
  logic [31:0] seed = 32'h9C85;
  int err_total = 0;
  int n_compared = 0;
  comparator_group_sampling_ctrl uut (.*);
  pwm_src u_pwm (.clk(clk), .hi_len(hi_len), .lo_len(lo_len), .pwm(pwm_in));
  always #5 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [2:0] exp_en(input int m, input int p);
    if (p == 0) return (m == 3) ? 3'b011 : 3'b111;
    if (p == 3) return (m == 3) ? 3'b000 : 3'b100;
    return 3'(1 << (p - 1));
  endfunction : exp_en
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Data launched at the strobe edge, taken at the next edge
    @(posedge clk);
    v = reg_rdata;
  endtask : rd
  // Bounded wait for the next edge into the given level
  task automatic edge_to(input logic lvl);
    int t = 0;
    while (pwm_in === lvl && t < 200) begin @(posedge clk); #1 t++; end
    while (pwm_in !== lvl && t < 200) begin @(posedge clk); #1 t++; end
    `CHK(t < 200, 1'b1)
  endtask : edge_to
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [31:0] r;
    logic [2:0] cur;
    logic [1:0] m, p;
    logic s, act;
    int rt;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 8'hD9; a <= 8'hDE; a++) begin
      rd(8'(a), v);
      `CHK(v, 8'h00)
    end
    // Every mode, pick and switch setting
    for (int i = 0; i < 32; i++) begin
      {s, m, p} = 5'(i);
      r = rnd();
      wr(8'hDC, {6'h00, s, r[0]});
      wr(8'hDA, {1'b0, m, p, 3'b000});
      @(posedge clk);
      #1 `CHK(comp_enable, exp_en(m, p))
      `CHK({neg_shared_ext, neg_resistor, neg_diff}, m == 1 ? 3'b010 : m == 2 ? 3'b001 : 3'b100)
      `CHK({pos_alt_b, pos_alt_c}, {(m == 1 && s) || m == 3, m == 1 && s})
      `CHK(aux_comparator_enable, r[0])
      rd(8'hDA, v);
      `CHK(v, {1'b0, m, p, 3'b000})
    end
    wr(8'hDA, 8'h00);
    wr(8'hDC, 8'h01);
    // Pass-through with sampling off; short glitches must vanish
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      rt = k % 5;
      wr(8'hDB, {3'b000, 3'(rt), 2'b00});
      comp_raw <= r[2:0];
      aux_raw <= r[3];
      repeat (14) @(posedge clk);
      comp_raw <= ~r[2:0];
      repeat (2) @(posedge clk);
      comp_raw <= r[2:0];
      repeat (12) begin
        @(posedge clk);
        #1 `CHK(timer_result, r[2:0])
      end
      `CHK(test_pin, (rt > 0 && rt < 4) ? r[rt - 1] : 1'b0)
      `CHK(func_pin, rt == 4 ? r[0] : 1'b0)
      rd(8'hDC, v);
      `CHK(v[7], r[3])
    end
    // Pick 01 masks the other results
    wr(8'hDA, 8'h08);
    repeat (2) @(posedge clk);
    #1 `CHK(timer_result, {2'b00, r[0]})
    wr(8'hDA, 8'h00);
    cur = r[2:0];
    wr(8'hDD, 8'h06);
    wr(8'hDE, 8'h02);
    // High, low and reserved-as-high sampling, with differing phase lengths in the low case only
    for (int sel = 1; sel <= 3; sel++) begin
      act = (sel != 2);
      hi_len <= act ? 8'h28 : 8'h23;
      lo_len <= act ? 8'h28 : 8'h3C;
      wr(8'hDB, 8'(sel));
      edge_to(act);
      edge_to(!act);
      // Synced edge lands 4 cycles late, window stays 4 more
      repeat (5) @(posedge clk);
      rd(8'hDF, v);
      `CHK(v[3], 1'b1)
      rd(8'hDF, v);
      `CHK(v[3], 1'b0)
      r = rnd();
      comp_raw <= r[2:0];
      repeat (15) @(posedge clk);
      #1 `CHK(timer_result, cur)
      cur = r[2:0];
      edge_to(act);
      // Window must still be shut 9 cycles on, open by 12
      repeat (8) @(posedge clk);
      rd(8'hDF, v);
      `CHK(v[3], 1'b0)
      rd(8'hDF, v);
      `CHK(v[3], 1'b1)
      `CHK(timer_result, cur)
    end
    end_of_test();
  end
  initial begin
    #200us;
    err_total++;
    end_of_test();
  end
endmodule : comparator_group_sampling_ctrl_tb_top
`default_nettype wire

/* sim/pwm_src.sv */
// Partner model: PWM generator standing in front of the block.
// Assumes the bench sets both phase lengths in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module pwm_src (
  // Clock
  input  wire logic       clk,
  // Phase lengths, changeable at run time
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  // PWM level
  output logic            pwm
);
  int cnt = 0;
  initial pwm = 1'b0;
  ////////////////////////////////////////
  // Free-running: the block times windows from either edge
  always @(posedge clk) begin
    if (cnt + 1 >= int'(pwm ? hi_len : lo_len)) begin
      pwm <= ~pwm;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pwm_src
`default_nettype wire
